/* tb/tmces_phy_model.sv */
`default_nettype none
module tmces_phy_model #(
    parameter int HALF_NS = 40
) (
    // phy transmit clock
    output var logic link_clk_out,
    // client side, qualified by the transmit enable
    input wire logic tx_en_in,
    output var int xfer_count_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // free-running phy clock, phase offset from the system clock
    initial begin
        link_clk_out = 1'b0;
        #13;
        forever #HALF_NS link_clk_out = ~link_clk_out;
    end

    // client bytes move only on enabled cycles
    always @(posedge link_clk_out) begin
        if (tx_en_in) begin
            xfer_count_out <= xfer_count_out + 1;
        end
    end
endmodule
`default_nettype wire

/* tb/tmces_top_tb.sv */
`default_nettype none
module tmces_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tmces_pkg::*;

    typedef struct {
        tmces_speed_t sel;
        logic low;
    } tmces_row_s;

    logic clk_in;
    logic resetn_in;
    logic link_clk;
    tmces_speed_t speed_sel;
    logic flag;
    logic tx_en;
    logic rx_en;
    logic cclk;
    logic byp;
    int xfers;
    int mismatches;
    int check_count;
    tmces_row_s rows [5];

    tmces_phy_model tmces_phy_model_inst (
        .link_clk_out(link_clk),
        .tx_en_in(tx_en),
        .xfer_count_out(xfers)
    );

    tmces_top tmces_top_inst (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .link_clk_in(link_clk),
        .speed_sel_in(speed_sel),
        .low_rate_speed_flag_out(flag),
        .tx_client_enable_out(tx_en),
        .rx_client_enable_out(rx_en),
        .mac_tx_client_clock_out(cclk),
        .client_clock_bypass_out(byp)
    );

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic chk(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_int(input string name, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic report_and_stop;
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic link_step;
        @(posedge link_clk);
        #1;
    endtask

    task automatic run_row(input tmces_row_s r);
        int k;
        int base;
        logic prev;
        logic pclk;
        @(negedge clk_in) speed_sel = r.sel;
        @(posedge clk_in);
        #1;
        chk("flag_early", !r.low, flag);
        @(posedge clk_in);
        #1;
        chk("low_rate_flag", r.low, flag);
        k = 0;
        do begin
            link_step();
            k++;
        end while (byp !== !r.low && k < 10);
        if (byp !== !r.low) begin
            mismatches++;
            report_and_stop();
        end
        chk("bypass_switch", !r.low, byp);
        // enable toggles from its gigabit high, so the first low-rate enable is low: no runt
        chk("first_enable", !r.low, tx_en);
        base = xfers;
        repeat (8) begin
            prev = tx_en;
            pclk = cclk;
            link_step();
            chk("tx_enable", r.low ? !prev : 1'b1, tx_en);
            chk("rx_enable", tx_en, rx_en);
            chk("bypass", !r.low, byp);
            chk("client_clock", r.low ? !pclk : 1'b0, cclk);
        end
        chk_int("transfers", r.low ? 4 : 8, xfers - base);
    endtask

    // watchdog so a stuck link clock cannot hang the run
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        mismatches = 0;
        check_count = 0;
        resetn_in = 1'b0;
        speed_sel = SPEED_1000;
        rows = '{'{SPEED_10, 1'b1}, '{SPEED_1000, 1'b0}, '{SPEED_100, 1'b1},
                 '{2'h3, 1'b0}, '{SPEED_10, 1'b1}};
        // link clock must tick once to clear its domain
        @(posedge link_clk);
        repeat (3) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (4) link_step();
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // reset in mid-run while toggling at low rate
        @(negedge clk_in) resetn_in = 1'b0;
        #1;
        chk("reset_flag", 1'b0, flag);
        repeat (2) link_step();
        chk("reset_tx_enable", 1'b0, tx_en);
        chk("reset_rx_enable", 1'b0, rx_en);
        chk("reset_clock", 1'b0, cclk);
        chk("reset_bypass", 1'b1, byp);
        @(negedge clk_in) resetn_in = 1'b1;
        // link side leaves reset on its second edge, gigabit until the level arrives
        repeat (2) link_step();
        chk("release_tx_enable", 1'b0, tx_en);
        chk("release_bypass", 1'b1, byp);
        link_step();
        chk("release_gig_enable", 1'b1, tx_en);
        link_step();
        chk("release_second_enable", 1'b1, tx_en);
        chk("release_flag", 1'b1, flag);
        run_row(rows[1]);
        run_row(rows[0]);
        report_and_stop();
    end
endmodule
`default_nettype wire

/* verilog/tmces_enable_gen.sv */
`default_nettype none
module tmces_enable_gen (
    // link clock and its reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // towards the top
    tmces_link_if.gen link
);
    import tmces_pkg::*;

    // alternate-cycle toggle, forced high at gigabit
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link.tx_en <= ENABLE_RESET;
        end else if (!link.low_rate) begin
            link.tx_en <= 1'b1;
        end else begin
            link.tx_en <= ~link.tx_en;
        end
    end

    // receive enable follows the same pattern on its own flop
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link.rx_en <= ENABLE_RESET;
        end else if (!link.low_rate) begin
            link.rx_en <= 1'b1;
        end else begin
            link.rx_en <= ~link.rx_en;
        end
    end

    // half-rate client clock at 10/100, parked low at gigabit
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link.clk_div <= CLKDIV_RESET;
        end else if (!link.low_rate) begin
            link.clk_div <= 1'b0;
        end else begin
            link.clk_div <= ~link.clk_div;
        end
    end

    // gigabit: client runs straight off the link clock
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link.bypass <= BYPASS_RESET;
        end else begin
            link.bypass <= ~link.low_rate;
        end
    end
endmodule
`default_nettype wire

/* verilog/tmces_link_if.sv */
`default_nettype none
interface tmces_link_if;
    logic low_rate;
    logic tx_en;
    logic rx_en;
    logic clk_div;
    logic bypass;

    // enable generator side
    modport gen (
        input low_rate,
        output tx_en,
        output rx_en,
        output clk_div,
        output bypass
    );

    // top side
    modport top (
        output low_rate,
        input tx_en,
        input rx_en,
        input clk_div,
        input bypass
    );
endinterface
`default_nettype wire

/* verilog/tmces_pkg.sv */
`default_nettype none
package tmces_pkg;

    // speed selection codes
    typedef logic [1:0] tmces_speed_t;

    localparam tmces_speed_t SPEED_10 = 2'h0;
    localparam tmces_speed_t SPEED_100 = 2'h1;
    localparam tmces_speed_t SPEED_1000 = 2'h2;

    // reset values
    localparam tmces_speed_t SPEED_RESET = SPEED_1000;
    localparam logic LOW_RATE_RESET = 1'b0;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic CLKDIV_RESET = 1'b0;
    localparam logic BYPASS_RESET = 1'b1;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;

    // synchroniser depth
    localparam int SYNC_STAGES = 2;

endpackage
`default_nettype wire

/* verilog/tmces_sync.sv */
`default_nettype none
module tmces_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    import tmces_pkg::*;

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= '0;
            q_out <= '0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* verilog/tmces_top.sv */
`default_nettype none

module tmces_top (
    // system clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,

    // link clock from the phy side
    input wire logic link_clk_in,

    // speed configuration
    input wire tmces_pkg::tmces_speed_t speed_sel_in,

    // speed status
    output logic low_rate_speed_flag_out,

    // client clock enables, link domain
    output logic tx_client_enable_out,
    output logic rx_client_enable_out,

    // client clock, link domain
    output logic mac_tx_client_clock_out,
    output logic client_clock_bypass_out
);
    import tmces_pkg::*;

    // reset synchronisers
    logic [1:0] sys_rst_q;
    logic [1:0] link_rst_q;
    logic sys_rstn;
    logic link_rstn;

    // system domain state
    tmces_speed_t speed_q;
    logic low_rate_d;

    // link domain signals
    logic low_rate_link;

    tmces_link_if link_bus ();

    // system reset: async assert, release after two edges
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sys_rst_q <= RST_SYNC_RESET;
        end else begin
            sys_rst_q <= {sys_rst_q[0], 1'b1};
        end
    end

    assign sys_rstn = sys_rst_q[1];

    // link reset released on the link clock; needs link edges
    always_ff @(posedge link_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            link_rst_q <= RST_SYNC_RESET;
        end else begin
            link_rst_q <= {link_rst_q[0], 1'b1};
        end
    end

    assign link_rstn = link_rst_q[1];

    // speed selection register
    always_ff @(posedge clk_in or negedge sys_rstn) begin
        if (!sys_rstn) begin
            speed_q <= SPEED_RESET;
        end else begin
            speed_q <= speed_sel_in;
        end
    end

    // unused code 3 is treated as gigabit
    always_comb begin
        case (speed_q)
            SPEED_10: low_rate_d = 1'b1;
            SPEED_100: low_rate_d = 1'b1;
            default: low_rate_d = 1'b0;
        endcase
    end

    // flag also lets outside logic steer its clock muxes
    always_ff @(posedge clk_in or negedge sys_rstn) begin
        if (!sys_rstn) begin
            low_rate_speed_flag_out <= LOW_RATE_RESET;
        end else begin
            low_rate_speed_flag_out <= low_rate_d;
        end
    end

    // level crossing into the link domain
    tmces_sync #(
        .WIDTH(1)
    ) tmces_sync_inst (
        .clk_in(link_clk_in),
        .rstn_in(link_rstn),
        .d_in(low_rate_speed_flag_out),
        .q_out(low_rate_link)
    );

    assign link_bus.low_rate = low_rate_link;

    // enables and client clock, all on the link clock
    tmces_enable_gen tmces_enable_gen_inst (
        .clk_in(link_clk_in),
        .rstn_in(link_rstn),
        .link(link_bus)
    );

    // outputs are the generator flops
    assign tx_client_enable_out = link_bus.tx_en;
    assign rx_client_enable_out = link_bus.rx_en;
    // half-rate clock feeds the client; bypass asks for the raw clock
    assign mac_tx_client_clock_out = link_bus.clk_div;
    assign client_clock_bypass_out = link_bus.bypass;

    // checks, link domain

    sequence s_low_twice;
        low_rate_link ##1 low_rate_link;
    endsequence

    sequence s_gig_step;
        !low_rate_link;
    endsequence

    property p_gig_enables_high;
        @(posedge link_clk_in) disable iff (!link_rstn)
        s_gig_step |=> (tx_client_enable_out && rx_client_enable_out);
    endproperty
    a_gig_enables_high: assert property (p_gig_enables_high)
        else $error("enable not high at gigabit");

    property p_alternate;
        @(posedge link_clk_in) disable iff (!link_rstn)
        s_low_twice |=> (tx_client_enable_out != $past(tx_client_enable_out));
    endproperty
    a_alternate: assert property (p_alternate)
        else $error("enable does not alternate at low rate");

    property p_no_runt;
        @(posedge link_clk_in) disable iff (!link_rstn)
        (low_rate_link && tx_client_enable_out) |=> !tx_client_enable_out;
    endproperty
    a_no_runt: assert property (p_no_runt)
        else $error("enable high twice in a row at low rate");

    property p_switch_one_cycle;
        @(posedge link_clk_in) disable iff (!link_rstn)
        $fell(low_rate_link) |=> (tx_client_enable_out && client_clock_bypass_out);
    endproperty
    a_switch_one_cycle: assert property (p_switch_one_cycle)
        else $error("speed change late on enables");

    property p_rx_tracks_tx;
        @(posedge link_clk_in) disable iff (!link_rstn)
        rx_client_enable_out == tx_client_enable_out;
    endproperty
    a_rx_tracks_tx: assert property (p_rx_tracks_tx)
        else $error("rx enable differs from tx enable");

    property p_clock_follows_speed;
        @(posedge link_clk_in) disable iff (!link_rstn)
        s_low_twice |=> (mac_tx_client_clock_out != $past(mac_tx_client_clock_out))
            && !client_clock_bypass_out;
    endproperty
    a_clock_follows_speed: assert property (p_clock_follows_speed)
        else $error("client clock not half rate at low speed");

    property p_clock_parked_gig;
        @(posedge link_clk_in) disable iff (!link_rstn)
        s_gig_step |=> (client_clock_bypass_out && !mac_tx_client_clock_out);
    endproperty
    a_clock_parked_gig: assert property (p_clock_parked_gig)
        else $error("client clock not bypassed at gigabit");

    property p_enable_reset_low;
        @(posedge link_clk_in) disable iff (!resetn_in)
        $rose(link_rstn) |-> !tx_client_enable_out;
    endproperty
    a_enable_reset_low: assert property (p_enable_reset_low)
        else $error("toggle not cleared by reset");

    sequence s_low_three;
        low_rate_link ##1 low_rate_link ##1 low_rate_link;
    endsequence

    sequence s_low_entry;
        !low_rate_link ##1 low_rate_link;
    endsequence

    property p_rx_no_runt;
        @(posedge link_clk_in) disable iff (!link_rstn)
        (low_rate_link && rx_client_enable_out) |=> !rx_client_enable_out;
    endproperty
    a_rx_no_runt: assert property (p_rx_no_runt)
        else $error("rx enable high twice in a row at low rate");

    property p_period_two;
        @(posedge link_clk_in) disable iff (!link_rstn)
        s_low_three |=> (tx_client_enable_out == $past(tx_client_enable_out, 2));
    endproperty
    a_period_two: assert property (p_period_two)
        else $error("enable period not two cycles at low rate");

    property p_low_entry;
        @(posedge link_clk_in) disable iff (!link_rstn)
        s_low_entry |=> (!tx_client_enable_out && !client_clock_bypass_out);
    endproperty
    a_low_entry: assert property (p_low_entry)
        else $error("first low-rate enable not low");

    // level is sampled two link edges late; history must lie past reset
    property p_sync_latency;
        @(posedge link_clk_in) disable iff (!link_rstn)
        $past(link_rstn, 2) |-> (low_rate_link == $past(low_rate_speed_flag_out, 2));
    endproperty
    a_sync_latency: assert property (p_sync_latency)
        else $error("speed level not carried to link side in two cycles");

    property p_reset_client_clock;
        @(posedge link_clk_in) disable iff (!resetn_in)
        $rose(link_rstn) |-> (!mac_tx_client_clock_out && client_clock_bypass_out
            && !rx_client_enable_out);
    endproperty
    a_reset_client_clock: assert property (p_reset_client_clock)
        else $error("client clock outputs not at reset level");

    // checks, system domain

    property p_flag_low_rate;
        @(posedge clk_in) disable iff (!sys_rstn)
        (speed_q == SPEED_10 || speed_q == SPEED_100) |=> low_rate_speed_flag_out;
    endproperty
    a_flag_low_rate: assert property (p_flag_low_rate)
        else $error("flag low at 10/100");

    property p_flag_gig;
        @(posedge clk_in) disable iff (!sys_rstn)
        (speed_q == SPEED_1000) |=> !low_rate_speed_flag_out;
    endproperty
    a_flag_gig: assert property (p_flag_gig)
        else $error("flag high at gigabit");

    property p_speed_reaches_flag;
        @(posedge clk_in) disable iff (!sys_rstn)
        (speed_sel_in == SPEED_1000) ##1 (speed_sel_in == SPEED_1000)
            |=> !low_rate_speed_flag_out;
    endproperty
    a_speed_reaches_flag: assert property (p_speed_reaches_flag)
        else $error("speed selection not reflected in two cycles");

    property p_speed_register;
        @(posedge clk_in) disable iff (!sys_rstn)
        sys_rstn |=> (speed_q == $past(speed_sel_in));
    endproperty
    a_speed_register: assert property (p_speed_register)
        else $error("speed register does not follow selection");

    property p_flag_not_low_rate;
        @(posedge clk_in) disable iff (!sys_rstn)
        (speed_q != SPEED_10 && speed_q != SPEED_100) |=> !low_rate_speed_flag_out;
    endproperty
    a_flag_not_low_rate: assert property (p_flag_not_low_rate)
        else $error("flag high for a gigabit or unused code");

    property p_flag_reset_low;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(sys_rstn) |-> !low_rate_speed_flag_out;
    endproperty
    a_flag_reset_low: assert property (p_flag_reset_low)
        else $error("flag not low out of reset");

    sequence s_sel_low_held;
        (speed_sel_in == SPEED_10 || speed_sel_in == SPEED_100) ##1
            (speed_sel_in == SPEED_10 || speed_sel_in == SPEED_100);
    endsequence

    property p_low_sel_reaches_flag;
        @(posedge clk_in) disable iff (!sys_rstn)
        s_sel_low_held |=> low_rate_speed_flag_out;
    endproperty
    a_low_sel_reaches_flag: assert property (p_low_sel_reaches_flag)
        else $error("low-rate selection not reflected in two cycles");

endmodule
`default_nettype wire
